// >>> hw/aclkg_cfg.svh
// Constants for the access-control key generator
`ifndef ACLKG_CFG_SVH
`define ACLKG_CFG_SVH
`define ACLKG_NUM_PORTS 53
`define ACLKG_PORT_W 6
`define ACLKG_NUM_RNG 8
`define ACLKG_HDR_BYTES 128
`define ACLKG_RAW1_BYTES 57
`define ACLKG_RAW2_BYTES 24
`define ACLKG_PLUS_20 8'h14
`define ACLKG_PLUS_40 8'h28
`define ACLKG_MAX_TAGS 2'h3
`define ACLKG_TAG_BYTES 8'h04
`define ACLKG_ETH_TLEN_POS 8'h0c
`define ACLKG_ETYPE_MIN 16'h0600
`define ACLKG_ETYPE_IP4 16'h0800
`define ACLKG_ETYPE_IP6 16'h86dd
`define ACLKG_ETYPE_ARP 16'h0806
`define ACLKG_ETYPE_RARP 16'h8035
`define ACLKG_ETYPE_OAM 16'h8902
`define ACLKG_TPID_C 16'h8100
`define ACLKG_TPID_S 16'h88a8
`define ACLKG_SNAP_SAP 8'haa
`define ACLKG_SNAP_CTL 8'h03
`define ACLKG_PROTO_TCP 8'h06
`define ACLKG_PROTO_UDP 8'h11
`define ACLKG_SEL_FRONT 2'h0
`define ACLKG_SEL_LOOP 2'h1
`define ACLKG_SEL_MASQ 2'h2
`define ACLKG_SEL_ALT 2'h3
`endif

// >>> hw/aclkg_pkg.sv
// Types for the access-control key generator
package aclkg_pkg;
   typedef enum logic [3:0] {
      ACLKG_FT_IP6_MC, ACLKG_FT_IP6_UC, ACLKG_FT_IP4_MC, ACLKG_FT_IP4_UC,
      ACLKG_FT_ARP, ACLKG_FT_OAM, ACLKG_FT_SNAP, ACLKG_FT_LLC,
      ACLKG_FT_ETYPE
   } aclkg_ftype_t;
   typedef enum logic [2:0] {
      ACLKG_KEY_MAC_ETHERTYPE_KEY, ACLKG_KEY_ARP, ACLKG_KEY_IP4_VLAN,
      ACLKG_KEY_IP6_VLAN, ACLKG_KEY_SEVEN_TUPLE, ACLKG_KEY_IP4_TRANSPORT,
      ACLKG_KEY_IP4_MISC, ACLKG_KEY_RAW
   } aclkg_key_t;
   typedef enum logic [2:0] {
      ACLKG_RNG_DPORT, ACLKG_RNG_SPORT, ACLKG_RNG_BOTH, ACLKG_RNG_VID,
      ACLKG_RNG_DSCP, ACLKG_RNG_FIELD
   } aclkg_rng_t;
   typedef enum logic [1:0] {
      ACLKG_SRC_FRONT, ACLKG_SRC_LOOP, ACLKG_SRC_MASQ, ACLKG_SRC_VD
   } aclkg_src_t;
endpackage : aclkg_pkg

// >>> hw/aclkg_range_chk.sv
// One range checker: input choice, applicability, inclusive compare
`timescale 1ns/100ps
`include "aclkg_cfg.svh"
module aclkg_range_chk (
   // Configuration
   input wire aclkg_pkg::aclkg_rng_t rng_type_i,
   input wire logic [15:0] lo_i,
   input wire logic [15:0] hi_i,
   // Frame values
   input wire logic l4_ok_i,
   input wire logic ip_ok_i,
   input wire logic [15:0] sport_i,
   input wire logic [15:0] dport_i,
   input wire logic [11:0] vid_i,
   input wire logic [5:0] dscp_i,
   input wire logic [15:0] field_i,
   // Result
   output logic hit_o
);
   import aclkg_pkg::*;

   function automatic logic in_rng(input logic [15:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (v >= lo) && (v <= hi);
   endfunction : in_rng

   always_comb begin
      hit_o = 1'b0;
      unique case (rng_type_i)
         ACLKG_RNG_DPORT: hit_o = l4_ok_i && in_rng(dport_i, lo_i, hi_i);
         ACLKG_RNG_SPORT: hit_o = l4_ok_i && in_rng(sport_i, lo_i, hi_i);
         ACLKG_RNG_BOTH: hit_o = l4_ok_i && (in_rng(sport_i, lo_i, hi_i) ||
                                  in_rng(dport_i, lo_i, hi_i));
         ACLKG_RNG_VID: hit_o = in_rng({4'h0, vid_i}, lo_i, hi_i);
         ACLKG_RNG_DSCP: hit_o = ip_ok_i && in_rng({10'h000, dscp_i}, lo_i,
                                  hi_i);
         ACLKG_RNG_FIELD: hit_o = in_rng(field_i, lo_i, hi_i);
         default: hit_o = 1'b0;
      endcase
   end
endmodule : aclkg_range_chk

// >>> hw/aclkg_top.sv
// Access-control key generation: type, key choice, ranges, VID, mask
// Notes on behaviour
// - Key made only when lookup enabled
// - Disabled lookup never matches frames
// - Non-IP non-ARP frames use MAC/EtherType key
// - Per-type allowed key list enforced
// - Custom key overrides port key choice
// - Two raw keys, classifier enabled
// - Raw keys 57 and 24 bytes
// - Ethernet positions: DMAC, payload, +20, +40
// - Control-word frames lack link position
// - Transport and 7-tuple keys get ranges
// - Eight range flags form range field
// - Port ranges: dest, source, either
// - VID all frames, DSCP IP only
// - 16-bit field after up to three tags
// - One field offset shared by all
// - Start and end both inclusive
// - Classified VID used by default
// - Routed frames use router-leg VIDs
// - Front port: selector 0, ingress bit
// - Loopback: selector 1, or 3
// - Masquerade: selector 0, or 2
// - Virtual device: selector 0, or 3
// - CPU injected: selector 0, empty, or 3
// - Nine frame types classified first
`timescale 1ns/100ps
`include "aclkg_cfg.svh"
module aclkg_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Frame in
   input wire logic frm_valid_i,
   input wire logic [`ACLKG_PORT_W-1:0] frm_port_i,
   input wire logic [8*`ACLKG_HDR_BYTES-1:0] frm_hdr_i,
   input wire logic frm_cw_i,
   input wire aclkg_pkg::aclkg_src_t frm_src_i,
   input wire logic frm_cpu_i,
   input wire logic [`ACLKG_PORT_W-1:0] frm_orig_port_i,
   // Upstream classifier results
   input wire logic [11:0] class_vid_i,
   input wire logic [5:0] class_dscp_i,
   input wire logic raw_key_enable_i,
   input wire logic [1:0] raw_key_position_i,
   input wire logic routable_flag_i,
   input wire logic [11:0] ingress_router_leg_i,
   input wire logic [11:0] egress_router_leg_i,
   // Per-port configuration, two lookups
   input wire logic [`ACLKG_NUM_PORTS-1:0] lookup_enable_i [2],
   input wire aclkg_pkg::aclkg_key_t port_key_select_cfg_i
      [2][`ACLKG_NUM_PORTS],
   input wire logic [`ACLKG_NUM_PORTS-1:0] router_leg_vid_enable_i,
   // Range checker configuration
   input wire aclkg_pkg::aclkg_rng_t range_type_cfg_i [`ACLKG_NUM_RNG],
   input wire logic [15:0] range_lo_cfg_i [`ACLKG_NUM_RNG],
   input wire logic [15:0] range_hi_cfg_i [`ACLKG_NUM_RNG],
   input wire logic [7:0] range_field_offset_cfg_i,
   // Source mask options: loop, masq, vd, cpu alternates
   input wire logic [3:0] source_mask_options_cfg_i,
   // Key out; valid, type, VID and mask-valid per lookup, the rest shared
   output logic key_valid_o [2],
   output aclkg_pkg::aclkg_key_t key_type_o [2],
   output logic [11:0] key_vid_o [2],
   output logic [`ACLKG_NUM_RNG-1:0] range_flags_field_o,
   output logic [1:0] source_mask_selector_o,
   output logic [`ACLKG_NUM_PORTS-1:0] source_port_bitmap_o,
   output logic mask_fields_valid_o [2],
   output aclkg_pkg::aclkg_ftype_t frame_type_o,
   output logic [8*`ACLKG_RAW1_BYTES-1:0] raw_key1_o,
   output logic [8*`ACLKG_RAW2_BYTES-1:0] raw_key2_o
);
   import aclkg_pkg::*;

   function automatic logic [7:0] hbyte(input logic [7:0] pos);
      // Positions past the header read as zero, not as unknown
      hbyte = pos[7] ? 8'h00 : frm_hdr_i[8*pos[6:0] +: 8];
   endfunction : hbyte

   function automatic logic [15:0] hword(input logic [7:0] pos);
      hword = {hbyte(pos), hbyte(pos + 8'h01)};
   endfunction : hword

   // Allowed key per frame type, fallback to MAC/EtherType
   function automatic aclkg_key_t legal_key(input aclkg_ftype_t ft,
                                            input aclkg_key_t k);
      legal_key = ACLKG_KEY_MAC_ETHERTYPE_KEY;
      unique case (ft)
         ACLKG_FT_IP4_MC: if (k == ACLKG_KEY_IP4_VLAN ||
            k == ACLKG_KEY_SEVEN_TUPLE || k == ACLKG_KEY_IP4_TRANSPORT ||
            k == ACLKG_KEY_IP4_MISC) legal_key = k;
         ACLKG_FT_IP4_UC: if (k == ACLKG_KEY_SEVEN_TUPLE ||
            k == ACLKG_KEY_IP4_TRANSPORT || k == ACLKG_KEY_IP4_MISC)
            legal_key = k;
         ACLKG_FT_IP6_MC: if (k == ACLKG_KEY_IP6_VLAN ||
            k == ACLKG_KEY_SEVEN_TUPLE) legal_key = k;
         ACLKG_FT_IP6_UC: if (k == ACLKG_KEY_SEVEN_TUPLE) legal_key = k;
         ACLKG_FT_ARP: if (k == ACLKG_KEY_ARP) legal_key = k;
         default: legal_key = ACLKG_KEY_MAC_ETHERTYPE_KEY;
      endcase
   endfunction : legal_key

   function automatic logic [`ACLKG_NUM_PORTS-1:0] port_bit(
      input logic [`ACLKG_PORT_W-1:0] p);
      port_bit = '0;
      if (p < `ACLKG_PORT_W'(`ACLKG_NUM_PORTS)) begin
         port_bit[p] = 1'b1;
      end
   endfunction : port_bit

   // Tag walk: type/len position after up to three VLAN tags
   logic [7:0] tlen_pos;
   logic [1:0] ntags;
   always_comb begin
      tlen_pos = `ACLKG_ETH_TLEN_POS;
      ntags = 2'h0;
      for (int t = 0; t < 3; t++) begin
         if (ntags == 2'(t) && (hword(tlen_pos) == `ACLKG_TPID_C ||
             hword(tlen_pos) == `ACLKG_TPID_S)) begin
            tlen_pos = tlen_pos + `ACLKG_TAG_BYTES;
            ntags = ntags + 2'h1;
         end
      end
   end

   logic [15:0] tlen;
   logic [7:0] l3_pos;
   logic [7:0] l4_pos;
   logic [7:0] ip_proto;
   logic ip4_mcast;
   logic ip6_mcast;
   logic is_ip4;
   logic is_ip6;
   logic is_l4;
   logic [7:0] l3_b0;
   // A process, not assigns: the helpers read the header directly
   always_comb begin
      tlen = hword(tlen_pos);
      l3_pos = tlen_pos + 8'h02;
      l3_b0 = hbyte(l3_pos);
      is_ip4 = (tlen == `ACLKG_ETYPE_IP4) && (l3_b0[7:4] == 4'h4);
      is_ip6 = (tlen == `ACLKG_ETYPE_IP6) && (l3_b0[7:4] == 4'h6);
      ip4_mcast = (hbyte(l3_pos + 8'h10) & 8'hf0) == 8'he0;
      ip6_mcast = hbyte(l3_pos + 8'h18) == 8'hff;
      ip_proto = is_ip6 ? hbyte(l3_pos + 8'h06) : hbyte(l3_pos + 8'h09);
      // Options in the IPv4 header are honoured via IHL
      l4_pos = is_ip6 ? l3_pos + `ACLKG_PLUS_40 :
               l3_pos + {2'h0, l3_b0[3:0], 2'h0};
      is_l4 = (is_ip4 || is_ip6) && (ip_proto == `ACLKG_PROTO_TCP ||
              ip_proto == `ACLKG_PROTO_UDP);
   end

   aclkg_ftype_t ftype;
   always_comb begin
      if (is_ip6) begin
         ftype = ip6_mcast ? ACLKG_FT_IP6_MC : ACLKG_FT_IP6_UC;
      end else if (is_ip4) begin
         ftype = ip4_mcast ? ACLKG_FT_IP4_MC : ACLKG_FT_IP4_UC;
      end else if (tlen == `ACLKG_ETYPE_ARP || tlen == `ACLKG_ETYPE_RARP) begin
         ftype = ACLKG_FT_ARP;
      end else if (tlen == `ACLKG_ETYPE_OAM) begin
         ftype = ACLKG_FT_OAM;
      end else if (tlen < `ACLKG_ETYPE_MIN) begin
         ftype = (hbyte(l3_pos) == `ACLKG_SNAP_SAP &&
                  hbyte(l3_pos + 8'h01) == `ACLKG_SNAP_SAP &&
                  hbyte(l3_pos + 8'h02) == `ACLKG_SNAP_CTL) ?
                 ACLKG_FT_SNAP : ACLKG_FT_LLC;
      end else begin
         ftype = ACLKG_FT_ETYPE;
      end
   end

   // Extraction start; link start not offered for CW
   logic [7:0] raw_pos;
   always_comb begin
      unique case (raw_key_position_i)
         2'h0: raw_pos = frm_cw_i ? l3_pos : 8'h00;
         2'h1: raw_pos = l3_pos;
         2'h2: raw_pos = l3_pos + `ACLKG_PLUS_20;
         2'h3: raw_pos = l3_pos + `ACLKG_PLUS_40;
      endcase
   end

   logic [15:0] sel_field;
   logic [15:0] sport;
   logic [15:0] dport;
   always_comb begin
      sel_field = hword(tlen_pos + range_field_offset_cfg_i);
      sport = hword(l4_pos);
      dport = hword(l4_pos + 8'h02);
   end

   logic [`ACLKG_NUM_RNG-1:0] rng_hit;
   for (genvar r = 0; r < `ACLKG_NUM_RNG; r++) begin : g_rng
      // Every frame compared against all checkers
      aclkg_range_chk u_chk (
         .rng_type_i(range_type_cfg_i[r]),
         .lo_i(range_lo_cfg_i[r]),
         .hi_i(range_hi_cfg_i[r]),
         .l4_ok_i(is_l4),
         .ip_ok_i(is_ip4 || is_ip6),
         .sport_i(sport),
         .dport_i(dport),
         .vid_i(class_vid_i),
         .dscp_i(class_dscp_i),
         .field_i(sel_field),
         .hit_o(rng_hit[r])
      );
   end

   // Key choice per lookup
   aclkg_key_t key_d [2];
   logic [11:0] vid_d [2];
   logic en_d [2];
   logic rt_en;
   assign rt_en = (frm_port_i < `ACLKG_PORT_W'(`ACLKG_NUM_PORTS)) &&
                  router_leg_vid_enable_i[frm_port_i];
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         en_d[l] = frm_valid_i &&
                   (frm_port_i < `ACLKG_PORT_W'(`ACLKG_NUM_PORTS)) &&
                   lookup_enable_i[l][frm_port_i];
         if (raw_key_enable_i) begin
            key_d[l] = ACLKG_KEY_RAW;
         end else if (frm_port_i < `ACLKG_PORT_W'(`ACLKG_NUM_PORTS)) begin
            key_d[l] = legal_key(ftype, port_key_select_cfg_i[l][frm_port_i]);
         end else begin
            key_d[l] = ACLKG_KEY_MAC_ETHERTYPE_KEY;
         end
         vid_d[l] = class_vid_i;
         if (rt_en && routable_flag_i) begin
            vid_d[l] = (l == 0) ? ingress_router_leg_i : egress_router_leg_i;
         end
      end
   end

   // Source mask selector and bitmap
   logic [1:0] sel_d;
   logic [`ACLKG_NUM_PORTS-1:0] map_d;
   always_comb begin
      map_d = port_bit(frm_port_i);
      sel_d = `ACLKG_SEL_FRONT;
      if (frm_cpu_i) begin
         map_d = '0;
         sel_d = source_mask_options_cfg_i[3] ? `ACLKG_SEL_ALT :
                 `ACLKG_SEL_FRONT;
      end else begin
         unique case (frm_src_i)
            ACLKG_SRC_FRONT: sel_d = `ACLKG_SEL_FRONT;
            ACLKG_SRC_LOOP: sel_d = source_mask_options_cfg_i[0] ?
                                    `ACLKG_SEL_ALT : `ACLKG_SEL_LOOP;
            ACLKG_SRC_MASQ: sel_d = source_mask_options_cfg_i[1] ?
                                    `ACLKG_SEL_MASQ : `ACLKG_SEL_FRONT;
            ACLKG_SRC_VD: begin
               map_d = port_bit(frm_orig_port_i);
               sel_d = source_mask_options_cfg_i[2] ? `ACLKG_SEL_ALT :
                       `ACLKG_SEL_FRONT;
            end
         endcase
      end
   end

   // Registered key outputs
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int l = 0; l < 2; l++) begin
            key_valid_o[l] <= 1'b0;
            key_type_o[l] <= ACLKG_KEY_MAC_ETHERTYPE_KEY;
            key_vid_o[l] <= 12'h000;
            mask_fields_valid_o[l] <= 1'b0;
         end
      end else begin
         for (int l = 0; l < 2; l++) begin
            key_valid_o[l] <= en_d[l];
            key_type_o[l] <= key_d[l];
            key_vid_o[l] <= vid_d[l];
            // VLAN keys carry no source mask fields
            mask_fields_valid_o[l] <= en_d[l] &&
               key_d[l] != ACLKG_KEY_IP4_VLAN &&
               key_d[l] != ACLKG_KEY_IP6_VLAN;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         range_flags_field_o <= '0;
         source_mask_selector_o <= 2'h0;
         source_port_bitmap_o <= '0;
         frame_type_o <= ACLKG_FT_ETYPE;
      end else begin
         // Range field from eight flags, zero for other keys
         range_flags_field_o <= '0;
         for (int l = 0; l < 2; l++) begin
            if (key_d[l] == ACLKG_KEY_SEVEN_TUPLE ||
                key_d[l] == ACLKG_KEY_IP4_TRANSPORT) begin
               range_flags_field_o <= rng_hit;
            end
         end
         source_mask_selector_o <= sel_d;
         source_port_bitmap_o <= map_d;
         frame_type_o <= ftype;
      end
   end

   // Raw byte windows from the chosen position
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         raw_key1_o <= '0;
         raw_key2_o <= '0;
      end else begin
         for (int b = 0; b < `ACLKG_RAW1_BYTES; b++) begin
            raw_key1_o[8*b +: 8] <= hbyte(raw_pos + 8'(b));
         end
         for (int b = 0; b < `ACLKG_RAW2_BYTES; b++) begin
            raw_key2_o[8*b +: 8] <= hbyte(raw_pos + 8'(b));
         end
      end
   end
endmodule : aclkg_top

// >>> tb/aclkg_props.sv
// Port checker for the access-control key generator
`timescale 1ns/100ps
`include "aclkg_cfg.svh"
module aclkg_props (
   // Clock, reset and frame
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic frm_valid_i,
   input wire logic [`ACLKG_PORT_W-1:0] frm_port_i,
   input wire aclkg_pkg::aclkg_src_t frm_src_i,
   input wire logic frm_cpu_i,
   input wire logic raw_key_enable_i,
   input wire logic routable_flag_i,
   input wire logic [11:0] class_vid_i,
   input wire logic [11:0] ingress_router_leg_i,
   input wire logic [11:0] egress_router_leg_i,
   // Configuration
   input wire logic [`ACLKG_NUM_PORTS-1:0] lookup_enable_i [2],
   input wire logic [`ACLKG_NUM_PORTS-1:0] router_leg_vid_enable_i,
   // Key outputs
   input wire logic key_valid_o [2],
   input wire aclkg_pkg::aclkg_key_t key_type_o [2],
   input wire logic [11:0] key_vid_o [2],
   input wire logic [`ACLKG_NUM_RNG-1:0] range_flags_field_o,
   input wire logic [1:0] source_mask_selector_o,
   input wire logic [`ACLKG_NUM_PORTS-1:0] source_port_bitmap_o,
   input wire logic mask_fields_valid_o [2],
   input wire aclkg_pkg::aclkg_ftype_t frame_type_o
);
   import aclkg_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Guards the port index so the enable lookups never go out of range
   logic ok_p;
   assign ok_p = frm_valid_i && frm_port_i < `ACLKG_NUM_PORTS;
   a_lookup_gate: assert property (ok_p |=>
      key_valid_o[0] == $past(lookup_enable_i[0][frm_port_i]) &&
      key_valid_o[1] == $past(lookup_enable_i[1][frm_port_i]))
      else $error("key valid does not follow enable");
   a_no_port_silent: assert property (!ok_p |=>
      !key_valid_o[0] && !key_valid_o[1]) else $error("key without frame");
   a_fixed_key_type: assert property (frame_type_o inside {ACLKG_FT_OAM,
      ACLKG_FT_SNAP, ACLKG_FT_LLC, ACLKG_FT_ETYPE} |-> key_type_o[1] inside
      {ACLKG_KEY_MAC_ETHERTYPE_KEY, ACLKG_KEY_RAW}) else $error("bad key type");
   a_raw_override: assert property (ok_p && raw_key_enable_i |=>
      key_type_o[0] == ACLKG_KEY_RAW && key_type_o[1] == ACLKG_KEY_RAW)
      else $error("custom key not used");
   a_range_needs_key: assert property (!(key_type_o[0] inside
      {ACLKG_KEY_SEVEN_TUPLE, ACLKG_KEY_IP4_TRANSPORT}) && !(key_type_o[1]
      inside {ACLKG_KEY_SEVEN_TUPLE, ACLKG_KEY_IP4_TRANSPORT}) |->
      range_flags_field_o == '0) else $error("range flags on plain key");
   a_default_vid: assert property (ok_p && !routable_flag_i |=>
      key_vid_o[0] == $past(class_vid_i) && key_vid_o[1] == $past(class_vid_i))
      else $error("classified vid not used");
   a_router_leg_vid: assert property (ok_p && routable_flag_i &&
      router_leg_vid_enable_i[frm_port_i] |=> key_vid_o[0] ==
      $past(ingress_router_leg_i) && key_vid_o[1] == $past(egress_router_leg_i))
      else $error("router leg vid not used");
   a_front_mask: assert property (ok_p && !frm_cpu_i &&
      frm_src_i == ACLKG_SRC_FRONT |=> !mask_fields_valid_o[0] ||
      (source_mask_selector_o == 2'h0 && source_port_bitmap_o ==
      (53'h1 << $past(frm_port_i)))) else $error("front port mask wrong");
   c_raw: cover property (key_type_o[0] == ACLKG_KEY_RAW);
   c_routed: cover property (ok_p && routable_flag_i ##1 key_valid_o[0]);
   c_ranges: cover property (key_valid_o[1] && |range_flags_field_o);
endmodule : aclkg_props
bind aclkg_top aclkg_props u_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .frm_valid_i(frm_valid_i), .frm_port_i(frm_port_i), .frm_src_i(frm_src_i),
   .frm_cpu_i(frm_cpu_i), .raw_key_enable_i(raw_key_enable_i),
   .routable_flag_i(routable_flag_i), .class_vid_i(class_vid_i),
   .ingress_router_leg_i(ingress_router_leg_i),
   .egress_router_leg_i(egress_router_leg_i),
   .lookup_enable_i(lookup_enable_i),
   .router_leg_vid_enable_i(router_leg_vid_enable_i),
   .key_valid_o(key_valid_o), .key_type_o(key_type_o), .key_vid_o(key_vid_o),
   .range_flags_field_o(range_flags_field_o),
   .source_mask_selector_o(source_mask_selector_o),
   .source_port_bitmap_o(source_port_bitmap_o),
   .mask_fields_valid_o(mask_fields_valid_o), .frame_type_o(frame_type_o));

// >>> tb/aclkg_upstream.sv
// Upstream model: frame header for a requested frame type
`timescale 1ns/100ps
module aclkg_upstream (
   // Request
   input wire aclkg_pkg::aclkg_ftype_t kind_i,
   input wire logic tcp_i,
   input wire logic [15:0] sport_i,
   input wire logic [15:0] dport_i,
   input wire logic [1023:0] fill_i,
   // Header, untagged, byte n at bits 8n up
   output logic [1023:0] hdr_o
);
   import aclkg_pkg::*;
   // one header shape per frame type
   always_comb begin
      logic [1023:0] h;
      int l4;
      h = fill_i;
      l4 = 34;
      case (kind_i)
         ACLKG_FT_IP6_MC, ACLKG_FT_IP6_UC: begin
            h[96+:24] = 24'h60dd86;
            h[160+:8] = tcp_i ? 8'h06 : 8'h3b;
            h[304+:8] = kind_i == ACLKG_FT_IP6_MC ? 8'hff : 8'h20;
            l4 = 54;
         end
         ACLKG_FT_IP4_MC, ACLKG_FT_IP4_UC: begin
            h[96+:24] = 24'h450008;
            h[184+:8] = tcp_i ? 8'h06 : 8'h01;
            h[240+:8] = kind_i == ACLKG_FT_IP4_MC ? 8'he0 : 8'h0a;
         end
         ACLKG_FT_ARP: h[96+:16] = 16'h0608;
         ACLKG_FT_OAM: h[96+:16] = 16'h0289;
         ACLKG_FT_SNAP: h[96+:40] = 40'h03aaaa4000;
         ACLKG_FT_LLC: h[96+:40] = 40'h0342424000;
         default: h[96+:16] = 16'hf788;
      endcase
      // Ports big-endian, source first
      if (kind_i < ACLKG_FT_ARP) begin
         h[8*l4+:32] = {dport_i[7:0], dport_i[15:8], sport_i[7:0], sport_i[15:8]};
      end
      hdr_o = h;
   end
endmodule : aclkg_upstream

// >>> tb/aclkg_top_bench.sv
// Self-checking bench for the access-control key generator
`timescale 1ns/100ps
`include "aclkg_cfg.svh"
module aclkg_top_bench;
   import aclkg_pkg::*;
   logic clk_i = 1'b0, rst_b_i = 1'b0, fv = 1'b0, cpu = 1'b0, rke = 1'b0;
   logic rt = 1'b0, tcp = 1'b0, cw = 1'b0, kv [2], mfv [2];
   logic [1:0] rkp = '0, sel;
   logic [3:0] opt = '0;
   logic [5:0] port = '0, orig = '0, dscp = '0;
   logic [11:0] cvid = '0, irl = '0, erl = '0, kvid [2];
   logic [15:0] sp = '0, dp = '0, rlo [8], rhi [8];
   logic [52:0] rlen = '0, bmp, len [2] = '{default: '0};
   logic [1023:0] fill = '0, hdr;
   logic [7:0] rng, foff = '0;
   logic [455:0] rk1;
   logic [191:0] rk2;
   aclkg_src_t src = ACLKG_SRC_FRONT;
   aclkg_ftype_t kind = ACLKG_FT_ETYPE, ft;
   aclkg_key_t ksel [2][53], kt [2];
   aclkg_rng_t rtype [8];
   int num_errors = 0, n_compared = 0;
   aclkg_upstream up (.kind_i(kind), .tcp_i(tcp), .sport_i(sp), .dport_i(dp),
      .fill_i(fill), .hdr_o(hdr));
   aclkg_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .frm_valid_i(fv),
      .frm_port_i(port), .frm_hdr_i(hdr), .frm_cw_i(cw), .frm_src_i(src),
      .frm_cpu_i(cpu), .frm_orig_port_i(orig), .class_vid_i(cvid),
      .class_dscp_i(dscp), .raw_key_enable_i(rke), .raw_key_position_i(rkp),
      .routable_flag_i(rt), .ingress_router_leg_i(irl),
      .egress_router_leg_i(erl), .lookup_enable_i(len),
      .port_key_select_cfg_i(ksel), .router_leg_vid_enable_i(rlen),
      .range_type_cfg_i(rtype), .range_lo_cfg_i(rlo), .range_hi_cfg_i(rhi),
      .range_field_offset_cfg_i(foff), .source_mask_options_cfg_i(opt),
      .key_valid_o(kv), .key_type_o(kt), .key_vid_o(kvid),
      .range_flags_field_o(rng), .source_mask_selector_o(sel),
      .source_port_bitmap_o(bmp), .mask_fields_valid_o(mfv),
      .frame_type_o(ft), .raw_key1_o(rk1), .raw_key2_o(rk2));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic chk(input logic [455:0] s, input logic [455:0] e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic conclude();
      if (num_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   function automatic aclkg_key_t pick(aclkg_ftype_t f, aclkg_key_t k);
      logic ok;
      case (f)
         ACLKG_FT_IP4_MC: ok = k inside {[ACLKG_KEY_IP4_VLAN:ACLKG_KEY_IP4_MISC]}
            && k != ACLKG_KEY_IP6_VLAN;
         ACLKG_FT_IP4_UC: ok = k inside {[ACLKG_KEY_SEVEN_TUPLE:ACLKG_KEY_IP4_MISC]};
         ACLKG_FT_IP6_MC: ok = k inside {ACLKG_KEY_IP6_VLAN, ACLKG_KEY_SEVEN_TUPLE};
         ACLKG_FT_IP6_UC: ok = k == ACLKG_KEY_SEVEN_TUPLE;
         ACLKG_FT_ARP: ok = k == ACLKG_KEY_ARP;
         default: ok = 1'b0;
      endcase
      return ok ? k : ACLKG_KEY_MAC_ETHERTYPE_KEY;
   endfunction : pick
   function automatic logic in_r(int i, logic [15:0] v);
      return rlo[i] <= v && v <= rhi[i];
   endfunction : in_r
   function automatic logic [7:0] rng_exp();
      logic [7:0] r;
      logic l4;
      l4 = kind < ACLKG_FT_ARP && tcp;
      for (int i = 0; i < 8; i++) begin
         case (rtype[i])
            ACLKG_RNG_DPORT: r[i] = l4 && in_r(i, dp);
            ACLKG_RNG_SPORT: r[i] = l4 && in_r(i, sp);
            ACLKG_RNG_BOTH: r[i] = l4 && (in_r(i, dp) || in_r(i, sp));
            ACLKG_RNG_VID: r[i] = in_r(i, 16'(cvid));
            ACLKG_RNG_DSCP: r[i] = in_r(i, 16'(dscp));
            // Untagged frames: type/len sits at byte 12
            ACLKG_RNG_FIELD: r[i] = in_r(i, {hdr[8*(12+foff)+:8],
               hdr[8*(13+foff)+:8]});
            default: r[i] = 1'b0;
         endcase
      end
      return r;
   endfunction : rng_exp
   task automatic check_frame();
      aclkg_key_t k0, k1;
      logic ob, rok;
      int pos;
      chk(ft, kind);
      if (port >= 6'd53) begin
         chk(kv[0] | kv[1], 1'b0);
         return;
      end
      k0 = rke ? ACLKG_KEY_RAW : pick(kind, ACLKG_KEY_SEVEN_TUPLE);
      k1 = rke ? ACLKG_KEY_RAW : pick(kind, ksel[1][port]);
      chk({kv[0], kv[1]}, {len[0][port], len[1][port]});
      chk(kt[0], k0);
      chk(kt[1], k1);
      rok = k0 inside {ACLKG_KEY_SEVEN_TUPLE, ACLKG_KEY_IP4_TRANSPORT} ||
            k1 inside {ACLKG_KEY_SEVEN_TUPLE, ACLKG_KEY_IP4_TRANSPORT};
      chk(rng, rok ? rng_exp() : 8'h0);
      chk(mfv[1], len[1][port] && !(k1 inside {ACLKG_KEY_IP4_VLAN,
         ACLKG_KEY_IP6_VLAN}));
      if (kv[0]) chk(kvid[0], rt && rlen[port] ? irl : cvid);
      if (kv[1]) chk(kvid[1], rt && rlen[port] ? erl : cvid);
      ob = cpu ? opt[3] : src == ACLKG_SRC_FRONT ? 1'b0 : opt[src - 2'h1];
      if (mfv[0]) begin
         chk(sel, !ob ? (!cpu && src == ACLKG_SRC_LOOP ? 2'h1 : 2'h0) : (!cpu && src == ACLKG_SRC_MASQ ? 2'h2 : 2'h3));
         if (!ob) chk(bmp, cpu ? 53'h0 : 53'h1 << (src == ACLKG_SRC_VD ? orig : port));
      end
      // Control-word frames start position 0 at the payload
      pos = rkp == 2'h0 ? (cw ? 14 : 0) : rkp == 2'h1 ? 14 :
            rkp == 2'h2 ? 34 : 54;
      if (rke) chk(rk1, 456'(hdr >> (8 * pos)));
      if (rke) chk(rk2, 192'(hdr >> (8 * pos)));
   endtask : check_frame
   initial begin
      #(100 * 2000);
      num_errors++;
      conclude();
   end
   initial begin
      int np;
      void'($urandom(29234));
      for (int p = 0; p < 53; p++) begin
         ksel[0][p] = ACLKG_KEY_SEVEN_TUPLE;
         ksel[1][p] = ACLKG_KEY_MAC_ETHERTYPE_KEY;
      end
      for (int i = 0; i < 8; i++) begin
         rtype[i] = aclkg_rng_t'(i % 6);
         rlo[i] = 16'h0010;
         rhi[i] = 16'h0020;
      end
      // Field window edges are exactly the two IP type values
      rlo[5] = 16'h0800;
      rhi[5] = 16'h86dd;
      // Illegal type code must never match
      rtype[7] = aclkg_rng_t'(3'h6);
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      for (int it = 0; it < 400; it++) begin
         @(posedge clk_i);
         np = $urandom % 56;
         port <= 6'(np);
         kind <= aclkg_ftype_t'($urandom % 9);
         src <= aclkg_src_t'($urandom % 4);
         fv <= 1'b1;
         tcp <= 1'($urandom);
         cpu <= $urandom % 8 == 0;
         rke <= $urandom % 4 == 0;
         rt <= 1'($urandom);
         rkp <= 2'($urandom);
         cw <= 1'($urandom);
         foff <= 8'($urandom % 32);
         opt <= 4'($urandom);
         orig <= 6'($urandom % 53);
         cvid <= 12'($urandom % 64);
         dscp <= 6'($urandom);
         irl <= 12'($urandom);
         erl <= 12'($urandom);
         sp <= 16'($urandom % 64);
         // Hit both inclusive edges of checker 0 often
         dp <= it % 4 == 0 ? 16'h0010 : it % 4 == 1 ? 16'h0020 : 16'($urandom % 64);
         len[0] <= 53'({$urandom, $urandom});
         len[1] <= 53'({$urandom, $urandom});
         rlen <= 53'({$urandom, $urandom});
         if (np < 53) ksel[1][np] <= aclkg_key_t'($urandom % 7);
         for (int i = 1; i < 8; i++) begin
            if (i != 5) rlo[i] <= 16'($urandom % 64);
            if (i != 5) rhi[i] <= 16'($urandom % 64);
         end
         for (int w = 0; w < 32; w++) fill[32*w+:32] <= $urandom;
         @(posedge clk_i);
         #1;
         check_frame();
      end
      conclude();
   end
endmodule : aclkg_top_bench
